// file: pkg/aobf_pkg.sv
// Purpose: constants for the converter output bus formatter
// Assumes: one pclk cycle stands for one half cycle of sample_clock_in
// Notes:   register indexes are word indexes; byte address is four times the index
//
// Operation
// - configuration register 0x02 selects single-bus or dual-bus output.
// - single-bus mode places every sample on bus A at full rate.
// - single-bus strobe A toggles at half sample rate; each edge marks a word.
// - dual-bus mode splits consecutive samples over bus A and bus B.
// - dual-bus strobes run at half or quarter sample rate, chosen by configuration.
// - each bus has twelve data bits, a strobe and its own over-range flag; strobe B is a copy of strobe A.
// - register 0x05 selects offset binary or two's complement output.
// - without reset pulse the strobe divider phase versus data is undefined.
// - external reset pulse forces the strobe divider into a known state.
// - out-of-range samples clip to all zeros or all ones in offset binary (0x800 or 0x7FF in two's complement), never wrap.
// - the pipeline advances on every half cycle of the sample clock.
// - latency is 7 cycles single, 7.5 or 8.5 cycles dual.
// - over-range flag is high for a sample that was clipped.
// - sync mode turns over-range pin into sample marker, bus A single, B dual.
// - reset input is sampled on the falling sample clock edge.

package aobf_pkg;

   // ==========================================================
   // data widths
   localparam int unsigned DATA_W     = 12;
   localparam int unsigned RAW_W      = 14;
   localparam int unsigned WORD_W     = DATA_W + 2;   // data, over-range, marker
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned LEVEL_W    = 4;

   localparam logic [DATA_W-1:0] CODE_MAX = 12'hFFF;
   localparam logic [DATA_W-1:0] CODE_MIN = 12'h000;
   localparam logic signed [RAW_W:0] MID_CODE = 15'sh0800;
   localparam logic signed [RAW_W:0] TOP_CODE = 15'sh0FFF;

   // ==========================================================
   // latency in half cycles, minus one for the pipe tap
   localparam int unsigned LAT_SINGLE_HALF = 14;
   localparam int unsigned LAT_DUAL2_HALF  = 15;
   localparam int unsigned LAT_DUAL4_HALF  = 17;
   localparam int unsigned PIPE_DEPTH      = LAT_DUAL4_HALF;

   // ==========================================================
   // register map (word indexes)
   localparam logic [7:0] ADDR_W          = 8'h08;
   localparam logic [5:0] IDX_BUS_CFG     = 6'h02;
   localparam logic [5:0] IDX_FMT_CFG     = 6'h05;
   localparam logic [5:0] IDX_STATUS      = 6'h10;

   localparam int unsigned BUS_DUAL_BIT   = 0;
   localparam int unsigned BUS_DIV4_BIT   = 1;
   localparam int unsigned FMT_TWOS_BIT   = 0;
   localparam int unsigned FMT_SYNC_BIT   = 1;

   localparam logic [1:0] BUS_CFG_RST     = 2'h0;
   localparam logic [1:0] FMT_CFG_RST     = 2'h0;

   localparam int unsigned ST_LEVEL_LSB   = 0;
   localparam int unsigned ST_PAIR_BIT    = 4;
   localparam int unsigned ST_STRA_BIT    = 5;
   localparam int unsigned ST_ALIGN_BIT   = 6;

endpackage : aobf_pkg

// file: verilog/aobf_fifo.sv
// Purpose: small synchronous FIFO between converter core and output pipe
// Assumes: single clock, push and pop by valid and ready
// Notes:   level output shows the number of stored words
`timescale 1ns/10ps
`default_nettype none

module aobf_fifo #(
   parameter int unsigned WIDTH = 14,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // fill side
   input  wire logic                     push_valid,
   output logic                          push_ready,
   input  wire logic [WIDTH-1:0]         push_data,
   // drain side
   output logic                          pop_valid,
   input  wire logic                     pop_ready,
   output logic [WIDTH-1:0]              pop_data,
   output logic [$clog2(DEPTH):0]        level
);

   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [PW:0]      cnt_q, cnt_d;
   logic             do_push, do_pop;
   // ready is registered so that the top-level ready output comes from a flop
   logic             ready_q;

   // ==========================================================
   // pointers and count
   always_comb begin
      do_push    = push_valid && ready_q;
      do_pop     = pop_ready && (cnt_q != '0);
      push_ready = ready_q;
      pop_valid  = (cnt_q != '0);
      pop_data   = mem_q[rd_q];
      level      = cnt_q;
      wr_d       = do_push ? PW'(wr_q + 1'b1) : wr_q;
      rd_d       = do_pop  ? PW'(rd_q + 1'b1) : rd_q;
      cnt_d      = cnt_q;
      if (do_push && !do_pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         ready_q <= 1'b1;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         ready_q <= (cnt_d != (PW+1)'(DEPTH));
      end
   end

   // storage holds no control state, so it needs no reset
   always_ff @(posedge pclk) begin
      if (do_push) begin
         mem_q[wr_q] <= push_data;
      end
   end

endmodule : aobf_fifo
`default_nettype wire

// file: verilog/aobf_top.sv
// Purpose: output word formatter, bus demux and strobe divider of the converter
// Assumes: pclk is the half-cycle step clock; raw samples arrive signed
// Notes:   registers over APB, zero wait states
`timescale 1ns/10ps
`default_nettype none

module aobf_top (
   // clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // apb slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [7:0]                     paddr,
   input  wire logic [31:0]                    pwdata,
   output logic                                pready,
   output logic                                pslverr,
   output logic [31:0]                         prdata,
   // converter core samples
   input  wire logic                           raw_valid,
   output logic                                raw_ready,
   input  wire logic [aobf_pkg::RAW_W-1:0]     raw_sample,
   // external reset pin
   input  wire logic                           align_reset_pin,
   // bus a
   output logic [aobf_pkg::DATA_W-1:0]         bus_a_data,
   output logic                                bus_a_data_strobe,
   output logic                                bus_a_over_range_flag,
   // bus b
   output logic [aobf_pkg::DATA_W-1:0]         bus_b_data,
   output logic                                bus_b_data_strobe,
   output logic                                bus_b_over_range_flag
);

   localparam int unsigned DW = aobf_pkg::DATA_W;
   localparam int unsigned WW = aobf_pkg::WORD_W;
   localparam int unsigned PD = aobf_pkg::PIPE_DEPTH;

   // ==========================================================
   // registers
   logic [1:0]  bus_cfg_q, bus_cfg_d, fmt_cfg_q, fmt_cfg_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [5:0]  idx;
   logic        mapped;
   logic [aobf_pkg::LEVEL_W-1:0] level;
   logic        dual, div4, twos, sync_en;

   // ==========================================================
   // divider and reset pin
   logic        half_q, half_d, pair_q, pair_d, stra_q, stra_d;
   logic        rst_s1_q, rst_s2_q, rst_s3_q, rst_s3_d, aligned_q, aligned_d;
   logic        slot, reset_seen, upd, strobe_en;

   // ==========================================================
   // pipe and outputs
   logic [aobf_pkg::RAW_W-1:0] code_src;
   logic [WW-1:0] head, word_new, last_q, last_d;
   logic          head_valid;
   logic [WW-1:0] pipe_q [PD];
   logic [WW-1:0] pipe_d [PD];
   logic [WW-1:0] tap_a, tap_b;
   logic [DW-1:0] a_data_q, a_data_d, b_data_q, b_data_d;
   logic          a_ovr_q, a_ovr_d, b_ovr_q, b_ovr_d;
   logic signed [aobf_pkg::RAW_W:0] code;
   logic [DW-1:0] clip;
   logic          clipped;

   assign dual    = bus_cfg_q[aobf_pkg::BUS_DUAL_BIT];
   assign div4    = bus_cfg_q[aobf_pkg::BUS_DIV4_BIT];
   assign twos    = fmt_cfg_q[aobf_pkg::FMT_TWOS_BIT];
   assign sync_en = fmt_cfg_q[aobf_pkg::FMT_SYNC_BIT];

   // ==========================================================
   // apb slave: answer prepared in setup, pready high in access
   always_comb begin
      idx       = paddr[7:2];
      mapped    = (idx == aobf_pkg::IDX_BUS_CFG) || (idx == aobf_pkg::IDX_FMT_CFG)
                  || (idx == aobf_pkg::IDX_STATUS);
      pready_d  = psel && !penable;
      pslverr_d = psel && !penable && !mapped;
      prdata_d  = prdata_q;
      bus_cfg_d = bus_cfg_q;
      fmt_cfg_d = fmt_cfg_q;
      if (psel && !penable) begin
         prdata_d = 32'h0000_0000;
         if (!pwrite) begin
            unique case (idx)
               aobf_pkg::IDX_BUS_CFG: prdata_d[1:0] = bus_cfg_q;
               aobf_pkg::IDX_FMT_CFG: prdata_d[1:0] = fmt_cfg_q;
               aobf_pkg::IDX_STATUS: begin
                  prdata_d[aobf_pkg::ST_LEVEL_LSB +: aobf_pkg::LEVEL_W] = level;
                  prdata_d[aobf_pkg::ST_PAIR_BIT]  = pair_q;
                  prdata_d[aobf_pkg::ST_STRA_BIT]  = stra_q;
                  prdata_d[aobf_pkg::ST_ALIGN_BIT] = aligned_q;
               end
               default: prdata_d = 32'h0000_0000;
            endcase
         end
      end
      if (psel && penable && pready_q && pwrite) begin
         if (idx == aobf_pkg::IDX_BUS_CFG) begin
            bus_cfg_d = pwdata[1:0];
         end
         if (idx == aobf_pkg::IDX_FMT_CFG) begin
            fmt_cfg_d = pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_cfg_q <= aobf_pkg::BUS_CFG_RST;
         fmt_cfg_q <= aobf_pkg::FMT_CFG_RST;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         bus_cfg_q <= bus_cfg_d;
         fmt_cfg_q <= fmt_cfg_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // ==========================================================
   // sample buffer
   aobf_fifo #(
      .WIDTH (aobf_pkg::RAW_W),
      .DEPTH (aobf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .pclk       (pclk),
      .presetn    (presetn),
      .push_valid (raw_valid),
      .push_ready (raw_ready),
      .push_data  (raw_sample),
      .pop_valid  (head_valid),
      .pop_ready  (slot),
      .pop_data   (code_src),
      .level      (level)
   );

   // ==========================================================
   // divider, reset pin sampling
   // the strobe divider powers up unrelated to the data in flight
   always_comb begin
      slot       = half_q;                                // falling edge of sample clock
      reset_seen = slot && rst_s2_q && !rst_s3_q;
      // pin level as seen at the last slot, so a rise between slots is not lost
      rst_s3_d   = slot ? rst_s2_q : rst_s3_q;
      half_d     = !half_q;
      pair_d     = slot ? !pair_q : pair_q;
      upd        = slot && (!dual || pair_q);
      strobe_en  = slot && (!dual || !div4 || pair_q);
      stra_d     = strobe_en ? !stra_q : stra_q;
      aligned_d  = aligned_q || reset_seen;
      if (reset_seen) begin
         pair_d = 1'b0;
         stra_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_q    <= 1'b0;
         pair_q    <= 1'b0;
         stra_q    <= 1'b0;
         rst_s1_q  <= 1'b0;
         rst_s2_q  <= 1'b0;
         rst_s3_q  <= 1'b0;
         aligned_q <= 1'b0;
      end else begin
         half_q    <= half_d;
         pair_q    <= pair_d;
         stra_q    <= stra_d;
         rst_s1_q  <= align_reset_pin;
         rst_s2_q  <= rst_s1_q;
         rst_s3_q  <= rst_s3_d;
         aligned_q <= aligned_d;
      end
   end

   // ==========================================================
   // clipping and coding; an empty buffer repeats the last word
   always_comb begin
      code    = $signed({code_src[aobf_pkg::RAW_W-1], code_src}) + aobf_pkg::MID_CODE;
      clipped = 1'b0;
      if (code < 0) begin
         clip    = aobf_pkg::CODE_MIN;
         clipped = 1'b1;
      end else if (code > aobf_pkg::TOP_CODE) begin
         clip    = aobf_pkg::CODE_MAX;
         clipped = 1'b1;
      end else begin
         clip = code[DW-1:0];
      end
      if (twos) begin
         clip[DW-1] = !clip[DW-1];
      end
      head     = {reset_seen, clipped, clip};
      word_new = head_valid ? head : {reset_seen, last_q[WW-2:0]};
      last_d   = slot ? word_new : last_q;
   end

   // ==========================================================
   // half-cycle pipe, one stage per pclk
   assign pipe_d[0] = slot ? word_new : pipe_q[0];
   for (genvar k = 1; k < PD; k++) begin : g_pipe
      assign pipe_d[k] = pipe_q[k-1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= '0;
         for (int i = 0; i < PD; i++) begin
            pipe_q[i] <= '0;
         end
      end else begin
         last_q <= last_d;
         for (int i = 0; i < PD; i++) begin
            pipe_q[i] <= pipe_d[i];
         end
      end
   end

   // ==========================================================
   // bus demux and output registers
   always_comb begin
      if (!dual) begin
         tap_a = pipe_q[aobf_pkg::LAT_SINGLE_HALF-1];
         tap_b = '0;
      end else if (!div4) begin
         tap_a = pipe_q[aobf_pkg::LAT_DUAL2_HALF-1];
         tap_b = pipe_q[aobf_pkg::LAT_DUAL2_HALF-3];
      end else begin
         tap_a = pipe_q[aobf_pkg::LAT_DUAL4_HALF-1];
         tap_b = pipe_q[aobf_pkg::LAT_DUAL4_HALF-3];
      end
      a_data_d = a_data_q;
      b_data_d = b_data_q;
      a_ovr_d  = a_ovr_q;
      b_ovr_d  = b_ovr_q;
      if (upd) begin
         a_data_d = tap_a[DW-1:0];
         b_data_d = dual ? tap_b[DW-1:0] : b_data_q;
         if (!sync_en) begin
            a_ovr_d = tap_a[DW];
            b_ovr_d = dual && tap_b[DW];
         end else begin
            // marker on bus a in single, bus b in dual
            a_ovr_d = !dual && tap_a[DW+1];
            b_ovr_d = dual && (tap_a[DW+1] || tap_b[DW+1]);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_data_q <= '0;
         b_data_q <= '0;
         a_ovr_q  <= 1'b0;
         b_ovr_q  <= 1'b0;
      end else begin
         a_data_q <= a_data_d;
         b_data_q <= b_data_d;
         a_ovr_q  <= a_ovr_d;
         b_ovr_q  <= b_ovr_d;
      end
   end

   // receiving logic captures on these strobes
   assign bus_a_data            = a_data_q;
   assign bus_b_data            = b_data_q;
   assign bus_a_over_range_flag = a_ovr_q;
   assign bus_b_over_range_flag = b_ovr_q;
   assign bus_a_data_strobe     = stra_q;
   assign bus_b_data_strobe     = stra_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_SINGLE_B_HOLD: assert property (!dual && !$past(dual) |-> $stable(bus_b_data))
      else $error("bus b changed in single-bus mode");
   AST_SINGLE_STROBE: assert property (!dual && slot && !reset_seen |=> bus_a_data_strobe != $past(stra_q))
      else $error("strobe a did not toggle on a sample");
   AST_DUAL_HOLD: assert property (dual && slot && !pair_q && $stable(bus_cfg_q) |=> $stable(bus_a_data))
      else $error("dual bus a updated off the pair phase");
   AST_DIV4_HOLD: assert property (dual && div4 && slot && !pair_q && !reset_seen |=> $stable(bus_a_data_strobe))
      else $error("quarter-rate strobe toggled early");
   AST_RESET_DIV: assert property (reset_seen |=> !pair_q && !bus_a_data_strobe ##1 !bus_a_data_strobe)
      else $error("divider not forced by reset pin");
   AST_CLIP: assert property (slot && head_valid && code > aobf_pkg::TOP_CODE && !twos
                              |=> pipe_q[0][DW-1:0] == aobf_pkg::CODE_MAX && pipe_q[0][DW])
      else $error("high sample not clipped and flagged");
   AST_PIPE_STEP: assert property (1'b1 |=> pipe_q[PD-1] == $past(pipe_q[PD-2]))
      else $error("pipe did not advance");
   AST_SYNC_PIN: assert property ($past(upd && sync_en && dual) |-> !bus_a_over_range_flag)
      else $error("bus a marker used in dual sync mode");
   AST_APB_ERR: assert property (psel && !penable && !mapped |=> pslverr && pready)
      else $error("unmapped access not refused");

endmodule : aobf_top
`default_nettype wire

// file: sim/aobf_capture_model.sv
// Purpose: receiving capture logic beside both output buses
// Assumes: data and strobe change together, so both are stable at the next pclk edge
// Notes:   a word is taken on every strobe edge; repeated words are dropped
`timescale 1ns/10ps
`default_nettype none

module aobf_capture_model (
   // clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // bus a
   input  wire logic [aobf_pkg::DATA_W-1:0] a_data,
   input  wire logic                       a_strobe,
   input  wire logic                       a_flag,
   // bus b
   input  wire logic [aobf_pkg::DATA_W-1:0] b_data,
   input  wire logic                       b_strobe,
   input  wire logic                       b_flag
);
   // ==========================================================
   // capture
   logic [25:0] words[$];
   logic [25:0] now_w;
   logic [25:0] last_w = '0;
   logic        last_s = 1'b0;
   int          gap    = 0;
   int          cnt    = 0;
   int          skew   = 0;

   assign now_w = {b_flag, b_data, a_flag, a_data};

   always @(posedge pclk) begin
      cnt = cnt + 1;
      if (b_strobe !== a_strobe) begin
         skew = skew + 1;
      end
      // no local clock: the strobe edge alone qualifies a word
      if (presetn && a_strobe !== last_s) begin
         gap = cnt;
         cnt = 0;
         if (now_w !== last_w) begin
            words.push_back(now_w);
         end
         last_w = now_w;
      end
      last_s = a_strobe;
   end
endmodule : aobf_capture_model
`default_nettype wire

// file: sim/adc_output_bus_formatter_bench.sv
// Purpose: self-checking bench for the output bus formatter
// Assumes: apb answers after one access cycle; samples pushed by valid and ready
// Notes:   stale repeated words before a burst are skipped when matching
`timescale 1ns/10ps
`default_nettype none

module adc_output_bus_formatter_bench;
   // ==========================================================
   // signals
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic        raw_valid = 1'b0;
   logic        raw_ready;
   logic [13:0] raw_sample = '0;
   logic        align_reset_pin = 1'b0;
   logic [11:0] a_data;
   logic [11:0] b_data;
   logic        a_strb;
   logic        b_strb;
   logic        a_flag;
   logic        b_flag;
   int          failures = 0;
   int          checks_done = 0;

   localparam logic [7:0] A_BUS  = {aobf_pkg::IDX_BUS_CFG, 2'b00};
   localparam logic [7:0] A_FMT  = {aobf_pkg::IDX_FMT_CFG, 2'b00};
   localparam logic [7:0] A_STAT = {aobf_pkg::IDX_STATUS, 2'b00};

   always #10 pclk = ~pclk;

   aobf_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_sample(raw_sample),
      .align_reset_pin(align_reset_pin), .bus_a_data(a_data), .bus_a_data_strobe(a_strb),
      .bus_a_over_range_flag(a_flag), .bus_b_data(b_data), .bus_b_data_strobe(b_strb),
      .bus_b_over_range_flag(b_flag));

   aobf_capture_model cap_u (
      .pclk(pclk), .presetn(presetn), .a_data(a_data), .a_strobe(a_strb), .a_flag(a_flag),
      .b_data(b_data), .b_strobe(b_strb), .b_flag(b_flag));

   // ==========================================================
   // checking and ending
   task automatic print_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic give_up();
      failures++;
      print_verdict();
   endtask : give_up

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check32

   task automatic check13(input logic [12:0] got, input logic [12:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check13

   // ==========================================================
   // apb master
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) give_up();
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic reg_write(input logic [7:0] addr, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, addr, d, rd, err);
   endtask : reg_write

   task automatic reg_check(input logic [7:0] addr, input logic [31:0] mask,
                            input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, addr, '0, rd, err);
      check32(rd & mask, exp);
      check32({31'h0, err}, {31'h0, exp_err});
   endtask : reg_check

   // ==========================================================
   // sample streams
   function automatic int raw_of(input int i, input int run);
      if (i == 2) return 4096;
      if (i == 5) return -3000;
      return run * 40 - 600 + i * 97;
   endfunction : raw_of

   // offset binary with clipping; two's complement flips the msb
   function automatic logic [12:0] exp_word(input int raw, input logic twos);
      logic [12:0] w;
      if (raw + 2048 < 0) w = 13'h1000;
      else if (raw + 2048 > 4095) w = 13'h1FFF;
      else w = {1'b0, 12'(raw + 2048)};
      w[11] = w[11] ^ twos;
      return w;
   endfunction : exp_word

   task automatic run_stream(input int run, input logic dual, input logic twos, input int gap);
      logic [12:0] seq[$];
      int          k;
      int          n;
      cap_u.words.delete();
      for (int i = 0; i < 8; i++) begin
         raw_valid  <= 1'b1;
         raw_sample <= 14'(raw_of(i, run));
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (raw_ready !== 1'b1 && n < 50);
         if (n >= 50) give_up();
      end
      raw_valid <= 1'b0;
      repeat (80) @(posedge pclk);
      foreach (cap_u.words[j]) begin
         seq.push_back(cap_u.words[j][12:0]);
         if (dual) seq.push_back(cap_u.words[j][25:13]);
      end
      k = 0;
      while (k < seq.size() && seq[k] !== exp_word(raw_of(0, run), twos)) k++;
      for (int i = 0; i < 8; i++) begin
         check13((k + i < seq.size()) ? seq[k + i] : 'x, exp_word(raw_of(i, run), twos));
      end
      check32(32'(cap_u.gap), 32'(gap));
   endtask : run_stream

   // ==========================================================
   // main sequence
   initial begin
      int n;
      int na;
      int nb;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      reg_check(A_BUS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
      reg_check(A_FMT, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
      reg_check(A_STAT, 32'h0000_004F, 32'h0000_0000, 1'b0);
      reg_write(A_BUS, 32'hFFFF_FFFF);
      reg_check(A_BUS, 32'hFFFF_FFFF, 32'h0000_0003, 1'b0);
      reg_write(8'h0C, 32'hFFFF_FFFF);
      reg_check(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
      reg_write(A_BUS, 32'h0000_0000);
      run_stream(0, 1'b0, 1'b0, 2);
      reg_write(A_FMT, 32'h0000_0001);
      run_stream(1, 1'b0, 1'b1, 2);
      reg_write(A_BUS, 32'h0000_0001);
      run_stream(2, 1'b1, 1'b1, 2);
      reg_write(A_FMT, 32'h0000_0000);
      reg_write(A_BUS, 32'h0000_0003);
      run_stream(3, 1'b1, 1'b0, 4);
      check32(32'(cap_u.skew), 32'h0000_0000);
      // fifo: pushing every cycle outruns the half-rate drain until refused
      raw_valid  <= 1'b1;
      raw_sample <= '0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (raw_ready === 1'b1 && n < 60);
      if (n >= 60) give_up();
      raw_valid <= 1'b0;
      repeat (60) @(posedge pclk);
      reg_check(A_STAT, 32'h0000_000F, 32'h0000_0000, 1'b0);
      // sync mode marks the sample seen at the alignment pulse: bus b in dual, bus a in single
      reg_write(A_FMT, 32'h0000_0002);
      for (int m = 1; m >= 0; m--) begin
         reg_write(A_BUS, 32'(m));
         repeat (40) @(posedge pclk);
         cap_u.words.delete();
         align_reset_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         align_reset_pin <= 1'b0;
         repeat (60) @(posedge pclk);
         na = 0;
         nb = 0;
         foreach (cap_u.words[j]) begin
            na += int'(cap_u.words[j][12]);
            nb += int'(cap_u.words[j][25]);
         end
         check32(32'(na), 32'(1 - m));
         check32(32'(nb), 32'(m));
      end
      reg_check(A_STAT, 32'h0000_0040, 32'h0000_0040, 1'b0);
      print_verdict();
   end
endmodule : adc_output_bus_formatter_bench
`default_nettype wire
